// [core/scl_count_clamp.sv]
// Minimum-value clamp for one period count.
// Assumes an unsigned count; purely combinational.
`timescale 1ns/100ps

module scl_count_clamp
  import scl_count_pkg::*;
#(
  parameter int          W   = 14,
  parameter logic [13:0] MIN = 14'h0006
)
(
  // Count as written
  input  wire logic [W-1:0] raw,
  // Count as stored
  output      logic [W-1:0] clamped
);

  // ----------------------------------------------------------------
  // Clamp
  // ----------------------------------------------------------------
  // Small values are raised to the minimum
  always_comb
  begin
    if (raw < MIN[W-1:0])
    begin
      clamped = MIN[W-1:0];
    end
    else
    begin
      clamped = raw;
    end
  end

endmodule : scl_count_clamp

// [core/scl_period_regs.sv]
// SCL period count registers with an AXI4-Lite slave and count selection.
// Assumes clk_sys is the controller input clock and that the SCL generator
// reports speed mode and high-speed preamble as synchronous levels.
`timescale 1ns/100ps

module scl_period_regs
  import scl_count_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  // AXI4-Lite write response
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  // AXI4-Lite read data
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // SCL generator side
  input  wire speed_t            speed_mode,
  input  wire logic              hs_preamble,
  input  wire scl_counts_t       std_counts,
  input  wire logic [13:0]       hs_low_count,
  // Interface enable and selected counts
  output      logic              iface_enable,
  output      scl_counts_t       scl_counts
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              ctrl_en;
    logic [13:0]       fast_high;
    logic [13:0]       fast_low;
    logic [13:0]       hs_high;
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    scl_counts_t       sel;
  } state_t;

  state_t      st_q;
  state_t      st_d;
  logic [1:0]  rst_sync_q;
  logic        rst_n_int;
  logic [13:0] fast_high_raw;
  logic [13:0] fast_low_raw;
  logic [13:0] hs_high_raw;
  logic [13:0] fast_high_clamped;
  logic [13:0] fast_low_clamped;
  logic [13:0] hs_high_clamped;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  // Asserts at once, releases after two edges
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n_int = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of new data over an old word, cut to the count width
  function automatic logic [13:0] merge_bytes(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return res[13:0];
  endfunction : merge_bytes

  // Zero-extend a count into a bus word
  function automatic logic [31:0] count_word(input logic [13:0] cnt);
    return {18'h0, cnt};
  endfunction : count_word

  // ----------------------------------------------------------------
  // Write data after byte merge, then clamped
  // ----------------------------------------------------------------
  // Partial writes merge into the stored value before clamping
  assign fast_high_raw = merge_bytes(count_word(st_q.fast_high), st_q.w_data,
                                     st_q.w_strb);
  assign fast_low_raw  = merge_bytes(count_word(st_q.fast_low), st_q.w_data,
                                     st_q.w_strb);
  assign hs_high_raw   = merge_bytes(count_word(st_q.hs_high), st_q.w_data,
                                     st_q.w_strb);

  scl_count_clamp #(
    .W   (CNT_W),
    .MIN (MIN_FAST_HIGH)
  ) u_clamp_fast_high (
    .raw     (fast_high_raw),
    .clamped (fast_high_clamped)
  );

  scl_count_clamp #(
    .W   (CNT_W),
    .MIN (MIN_FAST_LOW)
  ) u_clamp_fast_low (
    .raw     (fast_low_raw),
    .clamped (fast_low_clamped)
  );

  scl_count_clamp #(
    .W   (CNT_W),
    .MIN (MIN_HS_HIGH)
  ) u_clamp_hs_high (
    .raw     (hs_high_raw),
    .clamped (hs_high_clamped)
  );

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  // Write completes once address and data are both held and no write response is pending
  assign wr_fire = st_q.aw_held && st_q.w_held && !st_q.bvalid;
  assign rd_fire = s_axi_arvalid && st_q.arready;

  // Known write addresses
  always_comb
  begin
    case (st_q.aw_addr)
      OFF_CTRL, OFF_FAST_HIGH, OFF_FAST_LOW, OFF_HS_HIGH: wr_hit = 1'b1;
      default:                                            wr_hit = 1'b0;
    endcase
  end

  // Read decode; stored values read back as kept
  always_comb
  begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL:
      begin
        rd_word[CTRL_EN_BIT] = st_q.ctrl_en;
      end
      OFF_STATUS:
      begin
        rd_word[STAT_EN_BIT]  = st_q.ctrl_en;
        rd_word[STAT_PRE_BIT] = hs_preamble;
        rd_word[STAT_HS_BIT]  = (speed_mode == SPD_HIGH);
      end
      OFF_FAST_HIGH: rd_word = count_word(st_q.fast_high);
      OFF_FAST_LOW:  rd_word = count_word(st_q.fast_low);
      OFF_HS_HIGH:   rd_word = count_word(st_q.hs_high);
      default:
      begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;

    // Write address and data taken independently
    if (s_axi_awvalid && st_q.awready)
    begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready)
    begin
      st_d.w_held = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end

    // Register update and response
    if (wr_fire)
    begin
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if ((st_q.aw_addr == OFF_CTRL) && st_q.w_strb[0])
      begin
        st_d.ctrl_en = st_q.w_data[CTRL_EN_BIT];
      end
      // Count writes are dropped while the interface runs
      if (!st_q.ctrl_en)
      begin
        case (st_q.aw_addr)
          OFF_FAST_HIGH: st_d.fast_high = fast_high_clamped;
          OFF_FAST_LOW:  st_d.fast_low  = fast_low_clamped;
          OFF_HS_HIGH:   st_d.hs_high   = hs_high_clamped;
          default:       st_d.fast_high = st_q.fast_high;
        endcase
      end
    end
    if (st_q.bvalid && s_axi_bready)
    begin
      st_d.bvalid = 1'b0;
    end
    st_d.awready = !st_d.aw_held;
    st_d.wready  = !st_d.w_held;

    // Read path, one read at a time
    if (rd_fire)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = rd_word;
      st_d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_q.rvalid && s_axi_rready)
    begin
      st_d.rvalid = 1'b0;
    end
    st_d.arready = !st_d.rvalid;

    // Count selection for the SCL generator
    case (speed_mode)
      SPD_STD:
      begin
        st_d.sel = std_counts;
      end
      SPD_HIGH:
      begin
        // Preamble bytes run at fast timing
        if (hs_preamble)
        begin
          st_d.sel.high = st_q.fast_high;
          st_d.sel.low  = st_q.fast_low;
        end
        else
        begin
          st_d.sel.high = st_q.hs_high;
          st_d.sel.low  = hs_low_count;
        end
      end
      default:
      begin
        st_d.sel.high = st_q.fast_high;
        st_d.sel.low  = st_q.fast_low;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      st_q           <= '0;
      st_q.fast_high <= RST_FAST_HIGH;
      st_q.fast_low  <= RST_FAST_LOW;
      st_q.hs_high   <= RST_HS_HIGH;
      st_q.sel.high  <= RST_FAST_HIGH;
      st_q.sel.low   <= RST_FAST_LOW;
      st_q.awready   <= 1'b1;
      st_q.wready    <= 1'b1;
      st_q.arready   <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign iface_enable  = st_q.ctrl_en;
  assign scl_counts    = st_q.sel;

endmodule : scl_period_regs

// [shared/scl_count_pkg.sv]
// Constants, types and register map for the SCL period count registers.
// Assumes a 32-bit AXI4-Lite register bus and one clock that counts SCL periods.
package scl_count_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_STATUS      = 8'h04;
  localparam logic [7:0]  OFF_FAST_HIGH   = 8'h1c;
  localparam logic [7:0]  OFF_FAST_LOW    = 8'h20;
  localparam logic [7:0]  OFF_HS_HIGH     = 8'h24;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int          CNT_W           = 14;
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          STAT_EN_BIT     = 0;
  localparam int          STAT_PRE_BIT    = 1;
  localparam int          STAT_HS_BIT     = 2;

  // ----------------------------------------------------------------
  // Reset values and minimum counts
  // ----------------------------------------------------------------
  localparam logic [13:0] RST_FAST_HIGH   = 14'h003c;
  localparam logic [13:0] RST_FAST_LOW    = 14'h0082;
  localparam logic [13:0] RST_HS_HIGH     = 14'h0006;
  localparam logic [13:0] MIN_FAST_HIGH   = 14'h0006;
  localparam logic [13:0] MIN_FAST_LOW    = 14'h0008;
  localparam logic [13:0] MIN_HS_HIGH     = 14'h0006;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPD_STD,
    SPD_FAST,
    SPD_HIGH
  } speed_t;

  typedef struct packed {
    logic [13:0] high;
    logic [13:0] low;
  } scl_counts_t;

endpackage : scl_count_pkg

// [verification/scl_gen_model.sv]
// Behavioural SCL generator that reports bus phase to the count registers.
// Assumes the bench picks the phase; standard and HS low counts are fixed.
`timescale 1ns/100ps
module scl_gen_model
  import scl_count_pkg::*;
#(
  parameter logic [13:0] STD_HIGH = 14'h0190,
  parameter logic [13:0] STD_LOW  = 14'h01d6,
  parameter logic [13:0] HS_LOW   = 14'h0010
)
(
  // Clock, reset and phase request
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [1:0] phase,
  // Generator outputs
  output      speed_t      speed_mode,
  output      logic        hs_preamble,
  output      scl_counts_t std_counts,
  output      logic [13:0] hs_low_count
);
  assign std_counts   = {STD_HIGH, STD_LOW};
  assign hs_low_count = HS_LOW;
  // Phase 0 standard, 1 fast, 2 HS preamble, 3 HS data
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      speed_mode  <= SPD_STD;
      hs_preamble <= 1'b0;
    end
    else
    begin
      speed_mode  <= (phase == 2'h0) ? SPD_STD : (phase == 2'h1) ? SPD_FAST : SPD_HIGH;
      hs_preamble <= (phase == 2'h2);
    end
  end
endmodule : scl_gen_model

// [verification/scl_period_count_config_tb.sv]
// Self-checking bench for the SCL period count registers.
// Assumes a 50 MHz clock and the generator model on the count side.
`timescale 1ns/100ps
module scl_period_count_config_tb
  import scl_count_pkg::*;
;
  logic clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, iface_enable;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, phase;
  logic [3:0]  wstrb;
  speed_t      speed_mode;
  logic        hs_preamble;
  scl_counts_t std_counts, scl_counts;
  logic [13:0] hs_low_count;
  int          miscompares = 0;
  int          checked = 0;

  scl_gen_model gen (.clk_sys(clk_sys), .rst_n(rst_n), .phase(phase), .speed_mode(speed_mode),
    .hs_preamble(hs_preamble), .std_counts(std_counts), .hs_low_count(hs_low_count));
  scl_period_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .speed_mode(speed_mode), .hs_preamble(hs_preamble), .std_counts(std_counts),
    .hs_low_count(hs_low_count), .iface_enable(iface_enable), .scl_counts(scl_counts));

  // Clock and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial
  begin
    #400000;
    miscompares++;
    results();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bus write: both channels offered together, response checked
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       aw_go;
    logic       w_go;
    logic       b_go;
    logic [1:0] resp;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Handshakes judged mid-cycle on settled values, acted on at the next edge
    do
    begin
      @(negedge clk_sys);
      aw_go = awvalid && awready;
      w_go  = wvalid && wready;
      b_go  = bvalid;
      resp  = bresp;
      @(posedge clk_sys);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end while (!b_go);
    bready <= 1'b0;
    @(posedge clk_sys);
    chk({30'h0, resp}, {30'h0, er});
  endtask : wr

  // Bus read: data and response captured before the taking edge, checked one edge later
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        ar_go;
    logic        r_go;
    logic [31:0] got;
    logic [1:0]  resp;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // Data and response captured in the cycle rvalid stands
    do
    begin
      @(negedge clk_sys);
      ar_go = arvalid && arready;
      r_go  = rvalid;
      got   = rdata;
      resp  = rresp;
      @(posedge clk_sys);
      if (ar_go) arvalid <= 1'b0;
    end while (!r_go);
    rready <= 1'b0;
    @(posedge clk_sys);
    chk(got, ed);
    chk({30'h0, resp}, {30'h0, er});
  endtask : rd

  task automatic t_reset();
    rd(OFF_FAST_HIGH, 32'h3c, RESP_OKAY);
    rd(OFF_FAST_LOW, 32'h82, RESP_OKAY);
    rd(OFF_HS_HIGH, 32'h6, RESP_OKAY);
    $display("test reset values done");
  endtask : t_reset

  // Minimum clamps and reserved bits, read back as stored
  task automatic t_clamp();
    logic [7:0]  ad [7] = '{8'h1c, 8'h1c, 8'h1c, 8'h20, 8'h20, 8'h24, 8'h24};
    logic [31:0] wv [7] = '{0, 5, 32'hffffc123, 7, 8, 0, 32'hffffffff};
    logic [31:0] ev [7] = '{6, 6, 32'h0123, 8, 8, 6, 32'h3fff};
    for (int i = 0; i < 7; i++)
    begin
      wr(ad[i], wv[i], RESP_OKAY);
      rd(ad[i], ev[i], RESP_OKAY);
    end
    $display("test clamp done");
  endtask : t_clamp

  task automatic t_lock();
    wr(OFF_FAST_HIGH, 32'h40, RESP_OKAY);
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    wr(OFF_FAST_HIGH, 32'h100, RESP_OKAY);
    rd(OFF_FAST_HIGH, 32'h40, RESP_OKAY);
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    wr(OFF_FAST_HIGH, 32'h100, RESP_OKAY);
    rd(OFF_FAST_HIGH, 32'h100, RESP_OKAY);
    $display("test lock done");
  endtask : t_lock

  // Byte-ordered count programming, lower byte first
  task automatic t_bytes();
    wstrb <= 4'h1;
    wr(OFF_FAST_LOW, 32'h34, RESP_OKAY);
    wstrb <= 4'h2;
    wr(OFF_FAST_LOW, 32'h1200, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFF_FAST_LOW, 32'h1234, RESP_OKAY);
    $display("test byte order done");
  endtask : t_bytes

  // Each bus phase selects its counts while enabled
  task automatic t_select();
    logic [27:0] ex [4] = '{{14'h0190, 14'h01d6}, {14'h0021, 14'h0043},
                            {14'h0021, 14'h0043}, {14'h0006, 14'h0010}};
    logic [31:0] sx [4] = '{32'h1, 32'h1, 32'h7, 32'h5};
    wr(OFF_FAST_HIGH, 32'h21, RESP_OKAY);
    wr(OFF_FAST_LOW, 32'h43, RESP_OKAY);
    wr(OFF_HS_HIGH, 32'h6, RESP_OKAY);
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    for (int i = 1; i < 5; i++)
    begin
      phase <= i[1:0];
      repeat (4) @(posedge clk_sys);
      chk({4'h0, scl_counts}, {4'h0, ex[i % 4]});
      rd(OFF_STATUS, sx[i % 4], RESP_OKAY);
    end
    rd(OFF_STATUS, 32'h1, RESP_OKAY);
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    $display("test select done");
  endtask : t_select

  task automatic t_unmapped();
    wr(OFF_STATUS, 32'h1, RESP_SLVERR);
    rd(8'h3c, 32'h0, RESP_SLVERR);
    rd(OFF_CTRL, 32'h0, RESP_OKAY);
    $display("test unmapped done");
  endtask : t_unmapped

  // Reset again in mid-run with the interface enabled
  task automatic t_rereset();
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(OFF_FAST_HIGH, 32'h3c, RESP_OKAY);
    rd(OFF_FAST_LOW, 32'h82, RESP_OKAY);
    rd(OFF_CTRL, 32'h0, RESP_OKAY);
    $display("test second reset done");
  endtask : t_rereset

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    phase = 2'h0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_clamp();
    t_lock();
    t_bytes();
    t_select();
    t_unmapped();
    t_rereset();
    results();
  end
endmodule : scl_period_count_config_tb

// [verification/scl_period_regs_assertions.sv]
// Checker for the SCL period count registers.
// Assumes it is bound to scl_period_regs and sees only its ports.
`timescale 1ns/100ps
module scl_period_regs_assertions
  import scl_count_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Register bus read side
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // Count selection
  input wire speed_t      speed_mode,
  input wire logic        hs_preamble,
  input wire logic        iface_enable,
  input wire scl_counts_t scl_counts
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Selected fast and HS high counts never fall below their minimum
  a_fast_high_min: assert property (speed_mode == SPD_FAST |=> scl_counts.high >= 14'h0006)
    else $error("fast high count below minimum");
  a_fast_low_min: assert property (speed_mode == SPD_FAST |=> scl_counts.low >= 14'h0008)
    else $error("fast low count below minimum");
  a_hs_high_min: assert property (speed_mode == SPD_HIGH && !hs_preamble
    |=> scl_counts.high >= 14'h0006)
    else $error("hs high count below minimum");
  // Preamble of an HS transfer keeps the fast counts
  a_preamble_fast: assert property (iface_enable && speed_mode == SPD_FAST ##1 iface_enable
    && speed_mode == SPD_HIGH && hs_preamble |=> $stable(scl_counts))
    else $error("preamble not timed from fast counts");
  // Counts stay put while the interface is enabled in fast mode
  a_locked_stable: assert property ((iface_enable && speed_mode == SPD_FAST) [*3]
    |-> $stable(scl_counts))
    else $error("counts changed while enabled");
  a_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0)
    else $error("reserved read bits not zero");
  a_reset_counts: assert property ($rose(rst_n) |-> !iface_enable
    && scl_counts == {14'h003c, 14'h0082})
    else $error("reset counts wrong");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Main scenarios
  c_preamble: cover property (iface_enable && speed_mode == SPD_HIGH && hs_preamble);
  c_hs_data: cover property (speed_mode == SPD_HIGH && !hs_preamble);
  c_read_enabled: cover property (s_axi_rvalid && iface_enable);
endmodule : scl_period_regs_assertions

bind scl_period_regs scl_period_regs_assertions u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .speed_mode(speed_mode), .hs_preamble(hs_preamble),
  .iface_enable(iface_enable), .scl_counts(scl_counts));
